// ---- rtl/wdcu_top.sv ----
// module: watchdog countdown unit top with APB register slave and interrupt logic
// How it works
// [R1] enabling loads the full reload value first
// [R2] refresh instruction reloads counter, counting resumes
// [R3] debugger mode refreshes continuously, never times out
// [R4] counter reaching zero declares a timeout
// [R5] option bit picks interrupt or reset
// [R6] interrupt mode: request and set timeout flag
// [R7] after interrupt timeout wrap to all ones
// [R8] reading reset cause clears timeout flag
// [R9] stop plus interrupt mode: recovery and request
// [R10] stop timeout sets watchdog and stop flags
// [R11] keys 55 then aa unlock reload bytes
// [R12] unlock writes alter no stored bits
// [R13] control address writes unlock, reads cause
// [R14] reload is upper, high, low bytes
// [R15] reload writes store, reads return live count
// [R16] software keeps reload at four or above
// [R17] cause flags bits seven to four, read clears
// [R18] stop with watchdog flag marks watchdog recovery
// [R19] broken unlock order leaves reload locked
//
// Decided for this implementation: the APB slave port.
module wdcu_top (
    // clock and reset
    input wire logic         sys_clk,
    input wire logic         nrst,
    // apb slave
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [11:0]  paddr,
    input wire logic [31:0]  pwdata,
    input wire logic [3:0]   pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // core side
    input wire logic         refresh_instr,
    input wire logic         debug_mode,
    input wire logic         stop_mode,
    input wire logic         timeout_response_select,
    input wire logic         ext_reset_seen,
    // results
    output logic             wdt_irq_req,
    output logic             stop_recovery_req,
    output logic             system_reset_req,
    output logic             irq
);
    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        return a == r;
    endfunction : hit

    logic access;
    logic wr;
    logic rd;
    assign access = psel && penable;
    assign wr = access && pwrite && pstrb[0];
    assign rd = access && !pwrite;

    logic mapped;
    assign mapped = hit(paddr, wdcu_pkg::ADDR_UNLOCK_CTRL) || hit(paddr, wdcu_pkg::ADDR_RELOAD_UPPER)
                    || hit(paddr, wdcu_pkg::ADDR_RELOAD_HIGH) || hit(paddr, wdcu_pkg::ADDR_RELOAD_LOW)
                    || hit(paddr, wdcu_pkg::ADDR_CONTROL) || hit(paddr, wdcu_pkg::ADDR_IRQ_STATUS)
                    || hit(paddr, wdcu_pkg::ADDR_IRQ_MASK);

    // ---------------------------------------------------------------
    // unlock and reload storage
    // ---------------------------------------------------------------
    logic key_we;
    logic open;
    logic reload_we;
    // [R13] writes here only feed the unlock logic
    assign key_we = wr && hit(paddr, wdcu_pkg::ADDR_UNLOCK_CTRL);
    assign reload_we = wr && open && (hit(paddr, wdcu_pkg::ADDR_RELOAD_UPPER)
                       || hit(paddr, wdcu_pkg::ADDR_RELOAD_HIGH) || hit(paddr, wdcu_pkg::ADDR_RELOAD_LOW));

    // [R12] unlock writes store nothing
    wdcu_unlock u_unlock (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .key_we    (key_we),
        .key_data  (pwdata[7:0]),
        .reload_we (reload_we),
        .open      (open)
    );

    logic [23:0] reload_q;
    // [R11] reload changes only when unlocked
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reload_q <= wdcu_pkg::RELOAD_RESET;
        end else if (reload_we) begin
            // [R14] upper byte most significant
            if (hit(paddr, wdcu_pkg::ADDR_RELOAD_UPPER)) begin
                reload_q[23:16] <= pwdata[7:0];
            end
            if (hit(paddr, wdcu_pkg::ADDR_RELOAD_HIGH)) begin
                reload_q[15:8] <= pwdata[7:0];
            end
            if (hit(paddr, wdcu_pkg::ADDR_RELOAD_LOW)) begin
                reload_q[7:0] <= pwdata[7:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // enable and counter
    // ---------------------------------------------------------------
    logic enable_q;
    logic enable_wr;
    assign enable_wr = wr && hit(paddr, wdcu_pkg::ADDR_CONTROL);
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            enable_q <= 1'b0;
        end else if (enable_wr) begin
            enable_q <= pwdata[wdcu_pkg::CTRL_ENABLE_BIT];
        end
    end

    wdcu_cnt_if cif ();
    logic first_enable;
    // [R1] load on rising enable
    assign first_enable = enable_wr && pwdata[wdcu_pkg::CTRL_ENABLE_BIT] && !enable_q;
    // [R2] refresh reloads; [R3] debugger keeps refreshing
    assign cif.load = first_enable || (enable_q && (refresh_instr || debug_mode));
    assign cif.load_value = reload_q;
    assign cif.run = enable_q;

    wdcu_counter u_counter (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .cif     (cif)
    );

    // ---------------------------------------------------------------
    // timeout response
    // ---------------------------------------------------------------
    logic to_irq;
    logic to_rst;
    // [R5] option bit: 0 interrupt, 1 reset
    assign to_irq = cif.timeout && !timeout_response_select;
    assign to_rst = cif.timeout && timeout_response_select;

    // [R6] interrupt request pulse; [R9] plus stop recovery
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wdt_irq_req <= 1'b0;
            stop_recovery_req <= 1'b0;
            system_reset_req <= 1'b0;
        end else begin
            wdt_irq_req <= to_irq;
            stop_recovery_req <= to_irq && stop_mode;
            system_reset_req <= to_rst;
        end
    end

    // ---------------------------------------------------------------
    // reset cause register
    // ---------------------------------------------------------------
    logic [7:0] cause_q;
    logic cause_rd;
    assign cause_rd = rd && hit(paddr, wdcu_pkg::ADDR_UNLOCK_CTRL);
    // [R17] read clears upper bits; events set after a same-cycle read
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cause_q <= wdcu_pkg::CAUSE_RESET;
        end else begin
            if (cause_rd) begin
                cause_q[7:4] <= 4'h0;
            end
            if (cif.timeout) begin
                // [R8] flag set by timeout, cleared by read; [R10] stop flag too
                cause_q[wdcu_pkg::CAUSE_POR_BIT] <= 1'b0;
                cause_q[wdcu_pkg::CAUSE_WDT_BIT] <= 1'b1;
                // [R18] stop with watchdog marks watchdog recovery
                cause_q[wdcu_pkg::CAUSE_STOP_BIT] <= stop_mode;
            end
            if (ext_reset_seen) begin
                cause_q[wdcu_pkg::CAUSE_EXT_BIT] <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // interrupt status and mask
    // ---------------------------------------------------------------
    logic [wdcu_pkg::IRQ_BITS-1:0] irq_stat_q;
    logic [wdcu_pkg::IRQ_BITS-1:0] irq_mask_q;
    logic [wdcu_pkg::IRQ_BITS-1:0] irq_ev;
    logic [wdcu_pkg::IRQ_BITS-1:0] irq_clr;
    assign irq_ev[wdcu_pkg::IRQ_TIMEOUT_BIT] = to_irq;
    assign irq_ev[wdcu_pkg::IRQ_RESET_BIT] = to_rst;
    assign irq_clr = (wr && hit(paddr, wdcu_pkg::ADDR_IRQ_STATUS)) ? pwdata[wdcu_pkg::IRQ_BITS-1:0]
                                                                   : '0;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_mask_q <= wdcu_pkg::IRQ_MASK_RESET;
        end else if (wr && hit(paddr, wdcu_pkg::ADDR_IRQ_MASK)) begin
            irq_mask_q <= pwdata[wdcu_pkg::IRQ_BITS-1:0];
        end
    end
    // built from the next status value so the output is a flop that changes on the same edge as status
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_stat_q & ~irq_clr) | irq_ev) & irq_mask_q);
        end
    end

    // ---------------------------------------------------------------
    // apb answer: no wait state, data registered
    // ---------------------------------------------------------------
    logic [31:0] rdata_d;
    always_comb begin
        rdata_d = 32'h00000000;
        if (hit(paddr, wdcu_pkg::ADDR_UNLOCK_CTRL)) begin
            rdata_d[7:0] = cause_q;
        end else if (hit(paddr, wdcu_pkg::ADDR_RELOAD_UPPER)) begin
            // [R15] reads return live count
            rdata_d[7:0] = cif.count[23:16];
        end else if (hit(paddr, wdcu_pkg::ADDR_RELOAD_HIGH)) begin
            rdata_d[7:0] = cif.count[15:8];
        end else if (hit(paddr, wdcu_pkg::ADDR_RELOAD_LOW)) begin
            rdata_d[7:0] = cif.count[7:0];
        end else if (hit(paddr, wdcu_pkg::ADDR_CONTROL)) begin
            rdata_d[wdcu_pkg::CTRL_ENABLE_BIT] = enable_q;
        end else if (hit(paddr, wdcu_pkg::ADDR_IRQ_STATUS)) begin
            rdata_d[wdcu_pkg::IRQ_BITS-1:0] = irq_stat_q;
        end else if (hit(paddr, wdcu_pkg::ADDR_IRQ_MASK)) begin
            rdata_d[wdcu_pkg::IRQ_BITS-1:0] = irq_mask_q;
        end
    end

    // pready rises in the first access cycle edge; effects taken at the pready edge
    logic ack_q;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ack_q <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            ack_q <= psel && !penable;
            prdata <= rdata_d;
            pslverr <= psel && !penable && !mapped;
        end
    end
    assign pready = ack_q;
endmodule : wdcu_top

// ---- common/wdcu_pkg.sv ----
// package: register map, field positions and reset values of the watchdog countdown unit
package wdcu_pkg;
    // ---------------------------------------------------------------
    // register byte addresses
    // ---------------------------------------------------------------
    localparam logic [11:0] ADDR_UNLOCK_CTRL = 12'hff0;
    localparam logic [11:0] ADDR_RELOAD_UPPER = 12'hf00;
    localparam logic [11:0] ADDR_RELOAD_HIGH = 12'hf04;
    localparam logic [11:0] ADDR_RELOAD_LOW = 12'hf08;
    localparam logic [11:0] ADDR_CONTROL = 12'hf0c;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'hf10;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'hf14;
    // ---------------------------------------------------------------
    // unlock keys and field positions
    // ---------------------------------------------------------------
    localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'haa;
    localparam int CAUSE_POR_BIT = 7;
    localparam int CAUSE_STOP_BIT = 6;
    localparam int CAUSE_WDT_BIT = 5;
    localparam int CAUSE_EXT_BIT = 4;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int IRQ_TIMEOUT_BIT = 0;
    localparam int IRQ_RESET_BIT = 1;
    localparam int IRQ_BITS = 2;
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [23:0] RELOAD_RESET = 24'hffffff;
    localparam logic [23:0] COUNT_MAX = 24'hffffff;
    localparam logic [23:0] COUNT_ZERO = 24'h000000;
    localparam logic [7:0] CAUSE_RESET = 8'h80;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

    typedef enum logic [1:0] {
        WDCU_LOCKED = 2'b00,
        WDCU_HALF = 2'b01,
        WDCU_OPEN = 2'b11
    } wdcu_lock_t;
endpackage : wdcu_pkg

// ---- common/wdcu_cnt_if.sv ----
// interface: command and status bundle between the top and the down counter
interface wdcu_cnt_if;
    logic        load;
    logic [23:0] load_value;
    logic        run;
    logic [23:0] count;
    logic        timeout;
    modport ctl (output load, output load_value, output run, input count, input timeout);
    modport cnt (input load, input load_value, input run, output count, output timeout);
endinterface : wdcu_cnt_if

// ---- rtl/wdcu_counter.sv ----
// module: 24-bit down counter that pulses on reaching zero and wraps to all ones
module wdcu_counter (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // command side
    wdcu_cnt_if.cnt  cif
);
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cif.count <= wdcu_pkg::COUNT_MAX;
        end else if (cif.load) begin
            cif.count <= cif.load_value;
        end else if (cif.run) begin
            if (cif.count == wdcu_pkg::COUNT_ZERO) begin
                // [R7] wrap, no reload
                cif.count <= wdcu_pkg::COUNT_MAX;
            end else begin
                cif.count <= cif.count - 24'h000001;
            end
        end
    end

    // [R4] zero declares timeout
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cif.timeout <= 1'b0;
        end else begin
            cif.timeout <= cif.run && !cif.load && (cif.count == 24'h000001);
        end
    end
endmodule : wdcu_counter

// ---- rtl/wdcu_unlock.sv ----
// module: two-key unlock sequencer in front of the reload registers
module wdcu_unlock (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       nrst,
    // control address writes
    input wire logic       key_we,
    input wire logic [7:0] key_data,
    // reload write consumed
    input wire logic       reload_we,
    // state
    output logic           open
);
    wdcu_pkg::wdcu_lock_t state_q;
    wdcu_pkg::wdcu_lock_t state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            wdcu_pkg::WDCU_LOCKED: begin
                if (key_we && key_data == wdcu_pkg::UNLOCK_KEY_FIRST) begin
                    state_d = wdcu_pkg::WDCU_HALF;
                end
            end
            wdcu_pkg::WDCU_HALF: begin
                // [R11] exact 55 then aa
                if (key_we) begin
                    state_d = (key_data == wdcu_pkg::UNLOCK_KEY_SECOND) ? wdcu_pkg::WDCU_OPEN
                                                                         : wdcu_pkg::WDCU_LOCKED;
                end
            end
            wdcu_pkg::WDCU_OPEN: begin
                // [R19] broken order relocks
                if (key_we) begin
                    state_d = (key_data == wdcu_pkg::UNLOCK_KEY_FIRST) ? wdcu_pkg::WDCU_HALF
                                                                        : wdcu_pkg::WDCU_LOCKED;
                end
            end
            default: begin
                state_d = wdcu_pkg::WDCU_LOCKED;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= wdcu_pkg::WDCU_LOCKED;
        end else begin
            state_q <= state_d;
        end
    end

    assign open = (state_q == wdcu_pkg::WDCU_OPEN);
    // reload_we does not relock: all three bytes may be written after one unlock
    logic unused_we;
    assign unused_we = reload_we;
endmodule : wdcu_unlock

// ---- dv/wdcu_core_model.sv ----
// partner: core and interrupt controller model on the watchdog core side
module wdcu_core_model (
    // clock
    input wire logic sys_clk,
    // core requests
    output logic     refresh_instr,
    output logic     debug_mode,
    output logic     stop_mode,
    output logic     timeout_response_select,
    output logic     ext_reset_seen,
    // watchdog results
    input wire logic wdt_irq_req,
    input wire logic stop_recovery_req,
    input wire logic system_reset_req
);
    timeunit 1ns;
    timeprecision 1ps;
    int n_irq = 0;
    int n_smr = 0;
    int n_rst = 0;

    // option bit starts as interrupt; the testbench switches it to reset in t_resmode
    initial begin
        refresh_instr = 1'b0;
        debug_mode = 1'b0;
        stop_mode = 1'b0;
        timeout_response_select = 1'b0;
        ext_reset_seen = 1'b0;
    end

    // single-cycle requests are latched as counts
    always @(posedge sys_clk) begin
        n_irq <= n_irq + int'(wdt_irq_req === 1'b1);
        n_smr <= n_smr + int'(stop_recovery_req === 1'b1);
        n_rst <= n_rst + int'(system_reset_req === 1'b1);
    end

    // one refresh instruction lasts one cycle
    task refresh;
        refresh_instr <= 1'b1;
        @(posedge sys_clk);
        refresh_instr <= 1'b0;
    endtask : refresh

    task external_reset_flag;
        ext_reset_seen <= 1'b1;
        @(posedge sys_clk);
        ext_reset_seen <= 1'b0;
    endtask : external_reset_flag
endmodule : wdcu_core_model

// ---- dv/wdcu_checker.sv ----
// checker: timing properties seen at the watchdog unit ports
module wdcu_checker (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        nrst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // core side
    input wire logic        refresh_instr,
    input wire logic        debug_mode,
    input wire logic        stop_mode,
    input wire logic        timeout_response_select,
    input wire logic        ext_reset_seen,
    // results
    input wire logic        wdt_irq_req,
    input wire logic        stop_recovery_req,
    input wire logic        system_reset_req,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    AST_IRQ_PULSE: assert property (wdt_irq_req |=> !wdt_irq_req)
        else $error("interrupt request longer than one cycle");
    AST_IRQ_SELECT: assert property (wdt_irq_req |-> !timeout_response_select && !system_reset_req)
        else $error("interrupt request in reset mode");
    AST_RESET_SELECT: assert property (system_reset_req |-> timeout_response_select)
        else $error("reset request in interrupt mode");
    AST_STOP_RECOVERY: assert property (wdt_irq_req && stop_mode && $past(stop_mode, 2) |-> stop_recovery_req)
        else $error("no recovery for timeout in stop");
    AST_NO_RECOVERY: assert property (stop_recovery_req |-> wdt_irq_req && ($past(stop_mode) || $past(stop_mode, 2)))
        else $error("recovery without stop timeout");
    AST_DEBUG_QUIET: assert property (debug_mode && $past(debug_mode) && $past(debug_mode, 3)
        |-> !wdt_irq_req && !system_reset_req)
        else $error("timeout while debugging");
    AST_REFRESH_RELOAD: assert property (refresh_instr |-> ##3 (!wdt_irq_req && !system_reset_req)[*2])
        else $error("timeout right after refresh");
    AST_CAUSE_READ: assert property (psel && !penable && !pwrite && paddr == wdcu_pkg::ADDR_UNLOCK_CTRL
        |=> pready && prdata[31:8] == 24'h0 && prdata[3:0] == 4'h0)
        else $error("cause read has bits outside seven to four");

    cover property (stop_recovery_req);
    cover property (system_reset_req);
    cover property (pready && pslverr);
endmodule : wdcu_checker

bind wdcu_top wdcu_checker u_chk (.*);

// ---- dv/wdcu_tb_top.sv ----
// testbench: watchdog countdown unit driven over apb beside a core model
module wdcu_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, irq, m0, err;
    logic [31:0] prdata, rd;
    logic        refresh_instr, debug_mode, stop_mode, timeout_response_select, ext_reset_seen;
    logic        wdt_irq_req, stop_recovery_req, system_reset_req;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          n;

    always #2 sys_clk = ~sys_clk;

    wdcu_top u_dut (.*);
    wdcu_core_model u_core (.*);

    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // a bounded wait: a slave that never answers ends the run
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            mismatches++;
            $display("ERROR %0t no answer", $time);
            wrap_up();
        end
        // response taken at the pready edge; pslverr stands one cycle only
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    task rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc

    task irqs(input int di, input int ds, input int dr);
        chk(u_core.n_irq, di);
        chk(u_core.n_smr, ds);
        chk(u_core.n_rst, dr);
    endtask : irqs

    task t_reset;
        rdc(wdcu_pkg::ADDR_UNLOCK_CTRL, 32'h80);
        rdc(wdcu_pkg::ADDR_UNLOCK_CTRL, 32'h0);
        rdc(wdcu_pkg::ADDR_RELOAD_UPPER, 32'hff);
        rdc(wdcu_pkg::ADDR_IRQ_MASK, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
    endtask : t_reset

    task t_unlock;
        apb(1'b1, wdcu_pkg::ADDR_UNLOCK_CTRL, 32'h55);
        apb(1'b1, wdcu_pkg::ADDR_UNLOCK_CTRL, 32'haa);
        rdc(wdcu_pkg::ADDR_UNLOCK_CTRL, 32'h0);
        apb(1'b1, wdcu_pkg::ADDR_RELOAD_UPPER, 32'h0);
        apb(1'b1, wdcu_pkg::ADDR_RELOAD_HIGH, 32'h0);
        apb(1'b1, wdcu_pkg::ADDR_RELOAD_LOW, 32'h10);
        rdc(wdcu_pkg::ADDR_RELOAD_LOW, 32'hff);
        apb(1'b1, wdcu_pkg::ADDR_CONTROL, 32'h1);
        repeat (8) @(posedge sys_clk);
        irqs(0, 0, 0);
        repeat (16) @(posedge sys_clk);
        irqs(1, 0, 0);
        rdc(wdcu_pkg::ADDR_RELOAD_UPPER, 32'hff);
        $display("test unlock done");
    endtask : t_unlock

    task t_status;
        rdc(wdcu_pkg::ADDR_UNLOCK_CTRL, 32'h20);
        rdc(wdcu_pkg::ADDR_UNLOCK_CTRL, 32'h0);
        rdc(wdcu_pkg::ADDR_IRQ_STATUS, 32'h1);
        m0 = irq;
        apb(1'b1, wdcu_pkg::ADDR_IRQ_MASK, 32'h3);
        // irq flop follows the mask one edge after the write lands
        @(posedge sys_clk);
        chk({31'h0, irq ^ m0}, 32'h1);
        apb(1'b1, wdcu_pkg::ADDR_IRQ_MASK, m0 ? 32'h0 : 32'h3);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, wdcu_pkg::ADDR_IRQ_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rdc(wdcu_pkg::ADDR_IRQ_STATUS, 32'h0);
        $display("test status done");
    endtask : t_status

    task t_relock;
        apb(1'b1, wdcu_pkg::ADDR_UNLOCK_CTRL, 32'h55);
        apb(1'b1, wdcu_pkg::ADDR_UNLOCK_CTRL, 32'h12);
        apb(1'b1, wdcu_pkg::ADDR_UNLOCK_CTRL, 32'haa);
        apb(1'b1, wdcu_pkg::ADDR_RELOAD_HIGH, 32'h40);
        n = u_core.n_irq;
        u_core.refresh();
        repeat (24) @(posedge sys_clk);
        irqs(n + 1, 0, 0);
        n = u_core.n_irq;
        repeat (10) begin
            u_core.refresh();
            repeat (7) @(posedge sys_clk);
        end
        irqs(n, 0, 0);
        $display("test relock done");
    endtask : t_relock

    task t_debug;
        u_core.debug_mode <= 1'b1;
        repeat (60) @(posedge sys_clk);
        irqs(n, 0, 0);
        u_core.debug_mode <= 1'b0;
        repeat (24) @(posedge sys_clk);
        irqs(n + 1, 0, 0);
        rdc(wdcu_pkg::ADDR_UNLOCK_CTRL, 32'h20);
        $display("test debug done");
    endtask : t_debug

    task t_stop;
        u_core.stop_mode <= 1'b1;
        u_core.refresh();
        repeat (24) @(posedge sys_clk);
        irqs(n + 2, 1, 0);
        u_core.stop_mode <= 1'b0;
        rdc(wdcu_pkg::ADDR_UNLOCK_CTRL, 32'h60);
        $display("test stop done");
    endtask : t_stop

    task t_resmode;
        u_core.timeout_response_select <= 1'b1;
        u_core.refresh();
        repeat (24) @(posedge sys_clk);
        irqs(n + 2, 1, 1);
        rdc(wdcu_pkg::ADDR_UNLOCK_CTRL, 32'h20);
        apb(1'b0, wdcu_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk({31'h0, rd[1]}, 32'h1);
        u_core.external_reset_flag();
        rdc(wdcu_pkg::ADDR_UNLOCK_CTRL, 32'h10);
        $display("test reset mode done");
    endtask : t_resmode

    initial begin
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_unlock();
        t_status();
        t_relock();
        t_debug();
        t_stop();
        t_resmode();
        wrap_up();
    end
endmodule : wdcu_tb_top
